/* File: phase_align_buffer.sv */
module phase_align_buffer
    import tx_align_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Write side.
    input wire logic wr_en_in,
    input wire logic [WORD_W-1:0] wr_data_in,
    // Read side and control.
    input wire logic rd_en_in,
    input wire logic recentre_in,
    output logic [WORD_W-1:0] rd_data_out,
    output logic fault_out
);
    logic [BUF_DEPTH-1:0][WORD_W-1:0] mem_r;
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0] count_r;
    wire empty = (count_r == '0);
    wire full = (count_r == BUF_FULL);
    wire do_wr = wr_en_in && (!full || rd_en_in);
    wire do_rd = rd_en_in && !empty;
    wire overflow = wr_en_in && full && !rd_en_in;
    wire underflow = rd_en_in && empty;
    wire [PTR_W:0] count_nxt = count_r + {2'h0, do_wr} - {2'h0, do_rd};
    wire [PTR_W-1:0] wr_ptr_nxt = do_wr ? wr_ptr_r + 2'h1 : wr_ptr_r;
    // The next write pointer sets the read slip, so a final re-centre write is counted.
    wire [PTR_W-1:0] recentre_rd = wr_ptr_nxt - RECENTRE_FILL[PTR_W-1:0];

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mem_r <= '0;
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            rd_data_out <= '0;
            fault_out <= 1'b0;
        end
        else
        begin
            if (do_wr)
            begin
                mem_r[wr_ptr_r] <= wr_data_in;
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (do_rd)
            begin
                rd_data_out <= mem_r[rd_ptr_r];
            end
            // Re-centring slips the read side; characters may repeat or drop.
            if (recentre_in)
            begin
                rd_ptr_r <= recentre_rd;
                count_r <= RECENTRE_FILL;
            end
            else
            begin
                rd_ptr_r <= do_rd ? rd_ptr_r + 2'h1 : rd_ptr_r;
                count_r <= count_nxt;
            end
            fault_out <= !recentre_in && (overflow || underflow);
        end
    end
endmodule : phase_align_buffer

/* File: tx_align_pkg.sv */
package tx_align_pkg;
    localparam int LANES = 4;
    localparam int DATA_W = 8;
    localparam int CTRL_W = 2;
    localparam int WORD_W = DATA_W + CTRL_W;
    localparam int BUF_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int LANE_A = 0;
    localparam logic [PTR_W:0] RECENTRE_FILL = 3'h2;
    localparam logic [PTR_W:0] BUF_FULL = 3'h4;
    localparam int CLK_PERIOD_NS = 4;
    localparam int REF_PERIOD_NS = 64;
    localparam logic [3:0] CHAR_HALF_FULL = 4'(REF_PERIOD_NS / CLK_PERIOD_NS / 2);
    localparam logic [3:0] CHAR_HALF_HALF = 4'(REF_PERIOD_NS / CLK_PERIOD_NS / 4);
    localparam logic [1:0] REALIGN_MIN_LOWS = 2'h2;
    localparam logic [4:0] PLL_MULT_FULL = 5'h0A;
    localparam logic [4:0] PLL_MULT_HALF = 5'h14;
    typedef enum logic [1:0] {CKSEL_LOW = 2'h0, CKSEL_MID = 2'h1, CKSEL_HIGH = 2'h2} cksel_t;
endpackage : tx_align_pkg

/* File: tx_host_model.sv */
module tx_host_model
    import tx_align_pkg::*;
(
    // Reference clock.
    input wire logic ref_clock_in,
    // Lane clocks and characters.
    output logic [tx_align_pkg::LANES-1:0] lane_clock_out,
    output logic [tx_align_pkg::LANES-1:0][tx_align_pkg::DATA_W-1:0] lane_data_out,
    output logic [tx_align_pkg::LANES-1:0][tx_align_pkg::CTRL_W-1:0] lane_control_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] count_r = 8'h00;
    // Characters change mid-period, well clear of every capture edge.
    always @(negedge ref_clock_in) count_r <= count_r + 8'h01;
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        assign #(i * 5) lane_clock_out[i] = ref_clock_in;
        assign lane_data_out[i] = count_r ^ DATA_W'(8'h11 * i);
        assign lane_control_out[i] = CTRL_W'(i);
    end
endmodule : tx_host_model

/* File: tx_input_clock_phase_align.sv */
module tx_input_clock_phase_align
    import tx_align_pkg::*;
(
    // Internal character clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Reference clock domain.
    input wire logic ref_clock_in,
    input wire logic tx_phase_realign_n_in,
    // Static configuration pins.
    input wire tx_align_pkg::cksel_t tx_input_clock_select_in,
    input wire logic ref_half_rate_select_in,
    // Lane input clocks and parallel characters.
    input wire logic [tx_align_pkg::LANES-1:0] tx_lane_input_clock_in,
    input wire logic [tx_align_pkg::LANES-1:0][tx_align_pkg::DATA_W-1:0] tx_lane_data_in,
    input wire logic [tx_align_pkg::LANES-1:0][tx_align_pkg::CTRL_W-1:0] tx_lane_control_in,
    // Word sync sent by the encoder, one cycle per lane.
    input wire logic [tx_align_pkg::LANES-1:0] tx_word_sync_sent_in,
    // Encoder side.
    output logic [tx_align_pkg::LANES-1:0][tx_align_pkg::WORD_W-1:0] tx_enc_word_out,
    output logic tx_enc_strobe_out,
    output logic [tx_align_pkg::LANES-1:0] tx_lane_error_flag_out,
    // Clocking and status.
    output logic tx_char_clock_out,
    output logic tx_char_clock_n_out,
    output logic [4:0] tx_synth_pll_mult_out,
    output logic buffers_enabled_out,
    output logic realign_active_out
);
    import tx_align_pkg::*;

    // Reference domain: realign sampling and reference-clock capture.
    logic realign_s1_r;
    logic realign_s2_r;
    logic [1:0] low_cnt_r;
    logic realign_act_ref_r;
    logic ref_tgl_r;
    logic [LANES-1:0][WORD_W-1:0] ref_capt_r;

    always_ff @(posedge ref_clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            realign_s1_r <= 1'b1;
            realign_s2_r <= 1'b1;
            low_cnt_r <= '0;
            realign_act_ref_r <= 1'b0;
            ref_tgl_r <= 1'b0;
            ref_capt_r <= '0;
        end
        else
        begin
            realign_s1_r <= tx_phase_realign_n_in;
            realign_s2_r <= realign_s1_r;
            if (realign_s2_r)
            begin
                low_cnt_r <= '0;
                realign_act_ref_r <= 1'b0;
            end
            else if (low_cnt_r != REALIGN_MIN_LOWS)
            begin
                low_cnt_r <= low_cnt_r + 2'h1;
                realign_act_ref_r <= (low_cnt_r + 2'h1 == REALIGN_MIN_LOWS);
            end
            for (int i = 0; i < LANES; i++)
            begin
                ref_capt_r[i] <= {tx_lane_control_in[i], tx_lane_data_in[i]};
            end
            ref_tgl_r <= !ref_tgl_r;
        end
    end

    // Character domain synchronisers and character clock divider.
    logic [1:0] act_s_r;
    logic [2:0] tgl_s_r;
    logic [1:0] sel_s1_r;
    logic [1:0] sel_s2_r;
    logic [1:0] rate_s_r;
    logic [LANES-1:0][2:0] lclk_s_r;
    logic [LANES-1:0][WORD_W-1:0] ldat_s1_r;
    logic [LANES-1:0][WORD_W-1:0] ldat_s2_r;
    logic [3:0] div_cnt_r;
    logic char_clk_r;

    wire [1:0] sel = sel_s2_r;
    wire rate_half = rate_s_r[1];
    wire bypass = (sel == CKSEL_LOW) && !rate_half;
    wire buf_en = !bypass;
    wire realign_act = act_s_r[1] && buf_en;
    wire ref_evt = tgl_s_r[2] ^ tgl_s_r[1];
    wire [3:0] half_period = rate_half ? CHAR_HALF_HALF : CHAR_HALF_FULL;
    wire div_wrap = (div_cnt_r >= half_period - 4'h1);
    wire char_rise = div_wrap && !char_clk_r;
    wire tx_lane_a_input_clock = lclk_s_r[LANE_A][1];
    wire lane_a_rise = tx_lane_a_input_clock && !lclk_s_r[LANE_A][2];

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            act_s_r <= '0;
            tgl_s_r <= '0;
            sel_s1_r <= '0;
            sel_s2_r <= '0;
            rate_s_r <= '0;
            lclk_s_r <= '0;
            ldat_s1_r <= '0;
            ldat_s2_r <= '0;
            div_cnt_r <= '0;
            char_clk_r <= 1'b0;
            tx_char_clock_out <= 1'b0;
            tx_char_clock_n_out <= 1'b1;
            tx_enc_strobe_out <= 1'b0;
            tx_synth_pll_mult_out <= PLL_MULT_FULL;
            buffers_enabled_out <= 1'b0;
            realign_active_out <= 1'b0;
        end
        else
        begin
            act_s_r <= {act_s_r[0], realign_act_ref_r};
            tgl_s_r <= {tgl_s_r[1:0], ref_tgl_r};
            sel_s1_r <= tx_input_clock_select_in;
            sel_s2_r <= sel_s1_r;
            rate_s_r <= {rate_s_r[0], ref_half_rate_select_in};
            for (int i = 0; i < LANES; i++)
            begin
                lclk_s_r[i] <= {lclk_s_r[i][1:0], tx_lane_input_clock_in[i]};
                ldat_s1_r[i] <= {tx_lane_control_in[i], tx_lane_data_in[i]};
            end
            ldat_s2_r <= ldat_s1_r;
            div_cnt_r <= div_wrap ? 4'h0 : div_cnt_r + 4'h1;
            char_clk_r <= div_wrap ? !char_clk_r : char_clk_r;
            tx_char_clock_out <= char_clk_r;
            tx_char_clock_n_out <= !char_clk_r;
            tx_enc_strobe_out <= char_rise;
            tx_synth_pll_mult_out <= rate_half ? PLL_MULT_HALF : PLL_MULT_FULL;
            buffers_enabled_out <= buf_en;
            realign_active_out <= realign_act;
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : lane
            wire own_rise = lclk_s_r[g][1] && !lclk_s_r[g][2];
            wire ref_mode = (sel == CKSEL_LOW);
            wire wr_en = ref_mode ? ref_evt : (sel == CKSEL_MID) ? own_rise : lane_a_rise;
            wire [WORD_W-1:0] wr_data = ref_mode ? ref_capt_r[g] : ldat_s2_r[g];
            wire [WORD_W-1:0] buf_data;
            wire fault;
            logic err_nxt;
            logic [WORD_W-1:0] word_nxt;
            logic err_r;
            logic [WORD_W-1:0] word_r;
            logic [WORD_W-1:0] hold_r;

            phase_align_buffer pab
            (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .wr_en_in(wr_en && buf_en),
                .wr_data_in(wr_data),
                .rd_en_in(char_rise && buf_en),
                .recentre_in(realign_act),
                .rd_data_out(buf_data),
                .fault_out(fault)
            );

            always_comb
            begin
                err_nxt = err_r;
                if (tx_word_sync_sent_in[g] || realign_act)
                begin
                    err_nxt = 1'b0;
                end
                if (fault && buf_en)
                begin
                    err_nxt = 1'b1;
                end
                word_nxt = bypass ? hold_r : buf_data;
            end

            always_ff @(posedge clk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                begin
                    hold_r <= '0;
                    err_r <= 1'b0;
                    word_r <= '0;
                end
                else
                begin
                    hold_r <= (wr_en && bypass) ? wr_data : hold_r;
                    err_r <= err_nxt;
                    word_r <= char_rise ? word_nxt : word_r;
                end
            end

            assign tx_lane_error_flag_out[g] = err_r;
            assign tx_enc_word_out[g] = word_r;
        end
    endgenerate
endmodule : tx_input_clock_phase_align

/* File: tx_input_clock_phase_align_props.sv */
module tx_align_checker
    import tx_align_pkg::*;
(
    // Watched ports.
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic tx_phase_realign_n_in,
    input wire tx_align_pkg::cksel_t tx_input_clock_select_in,
    input wire logic ref_half_rate_select_in,
    input wire logic [LANES-1:0][WORD_W-1:0] tx_enc_word_out,
    input wire logic tx_enc_strobe_out,
    input wire logic tx_char_clock_out,
    input wire logic tx_char_clock_n_out,
    input wire logic [4:0] tx_synth_pll_mult_out,
    input wire logic buffers_enabled_out,
    input wire logic realign_active_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence hi_full_s; tx_char_clock_out [*8] ##1 !tx_char_clock_out; endsequence
    sequence hi_half_s; tx_char_clock_out [*4] ##1 !tx_char_clock_out; endsequence
    sequence cfg_still_s;
        ($stable(ref_half_rate_select_in) && $stable(tx_input_clock_select_in)) [*6];
    endsequence
    clock_pair_a: assert property (tx_char_clock_n_out == !tx_char_clock_out)
        else $error("char clock pair not complementary");
    full_rate_a: assert property ($rose(tx_char_clock_out) && tx_synth_pll_mult_out ==
        PLL_MULT_FULL && $past(tx_synth_pll_mult_out, 16) == PLL_MULT_FULL |-> hi_full_s)
        else $error("full rate half period wrong");
    half_rate_a: assert property ($rose(tx_char_clock_out) && tx_synth_pll_mult_out ==
        PLL_MULT_HALF && $past(tx_synth_pll_mult_out, 16) == PLL_MULT_HALF |-> hi_half_s)
        else $error("half rate half period wrong");
    pll_mult_a: assert property (cfg_still_s |-> tx_synth_pll_mult_out ==
        (ref_half_rate_select_in ? PLL_MULT_HALF : PLL_MULT_FULL)) else $error("multiplier");
    buf_enable_a: assert property (cfg_still_s |-> buffers_enabled_out ==
        (tx_input_clock_select_in != CKSEL_LOW || ref_half_rate_select_in))
        else $error("buffer enable wrong");
    realign_ignored_a: assert property (!buffers_enabled_out |-> !realign_active_out)
        else $error("realign active in bypass");
    realign_rise_a: assert property ($rose(realign_active_out) |->
        !$past(tx_phase_realign_n_in, 20)) else $error("realign rose too early");
    realign_fall_a: assert property ($fell(realign_active_out) |->
        $past(tx_phase_realign_n_in, 8)) else $error("realign dropped while low");
    strobe_space_a: assert property (tx_enc_strobe_out |=> !tx_enc_strobe_out [*3])
        else $error("strobes too close");
    word_hold_a: assert property (!tx_enc_strobe_out |-> $stable(tx_enc_word_out))
        else $error("word changed without strobe");
endmodule : tx_align_checker
bind tx_input_clock_phase_align tx_align_checker chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .tx_phase_realign_n_in(tx_phase_realign_n_in),
    .tx_input_clock_select_in(tx_input_clock_select_in),
    .ref_half_rate_select_in(ref_half_rate_select_in), .tx_enc_word_out(tx_enc_word_out),
    .tx_enc_strobe_out(tx_enc_strobe_out), .tx_char_clock_out(tx_char_clock_out),
    .tx_char_clock_n_out(tx_char_clock_n_out), .tx_synth_pll_mult_out(tx_synth_pll_mult_out),
    .buffers_enabled_out(buffers_enabled_out), .realign_active_out(realign_active_out));

/* File: tx_input_clock_phase_align_tb_top.sv */
module tx_input_clock_phase_align_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tx_align_pkg::*;
    logic clk_in = 1'b0;
    logic ref_clock = 1'b0;
    logic rst_b_in = 1'b0;
    logic realign_n = 1'b1;
    logic half = 1'b0;
    cksel_t sel = CKSEL_LOW;
    logic [LANES-1:0] lane_clk;
    logic [LANES-1:0][DATA_W-1:0] lane_data;
    logic [LANES-1:0][CTRL_W-1:0] lane_ctrl;
    logic [LANES-1:0][WORD_W-1:0] word;
    logic strobe, cko, cko_n, buf_en, active;
    logic [LANES-1:0] err;
    logic [4:0] mult;
    logic [LANES-1:0] wsync = 4'h0;
    int fails = 0;
    int tests_run = 0;
    always #2 clk_in = ~clk_in;
    always #32 ref_clock = ~ref_clock;
    tx_host_model host (.ref_clock_in(ref_clock), .lane_clock_out(lane_clk),
        .lane_data_out(lane_data), .lane_control_out(lane_ctrl));
    tx_input_clock_phase_align dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .ref_clock_in(ref_clock), .tx_phase_realign_n_in(realign_n),
        .tx_input_clock_select_in(sel), .ref_half_rate_select_in(half),
        .tx_lane_input_clock_in(lane_clk), .tx_lane_data_in(lane_data),
        .tx_lane_control_in(lane_ctrl), .tx_word_sync_sent_in(wsync),
        .tx_enc_word_out(word), .tx_enc_strobe_out(strobe), .tx_lane_error_flag_out(err),
        .tx_char_clock_out(cko), .tx_char_clock_n_out(cko_n), .tx_synth_pll_mult_out(mult),
        .buffers_enabled_out(buf_en), .realign_active_out(active));
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1)
        begin
            $display("mismatch at %0t: %s", $time, what);
            fails++;
        end
    endtask : chk
    task automatic wait_for(input int s, input logic lvl);
        int n;
        n = 0;
        while (((s == 0) ? strobe : (s == 1) ? active : |err) !== lvl && n < 400)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk(n < 400, "wait ran out");
        if (n >= 400) wrap_up();
    endtask : wait_for
    task automatic start(input cksel_t s, input logic h);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        sel <= s;
        half <= h;
        repeat (40) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (40) @(posedge clk_in);
        #1;
        chk(mult === (h ? PLL_MULT_HALF : PLL_MULT_FULL), "pll multiplier");
        chk(buf_en === (s != CKSEL_LOW || h), "buffer enable");
        chk(cko_n === ~cko, "clock pair");
    endtask : start
    task automatic realign(input logic on);
        @(posedge clk_in);
        realign_n <= 1'b0;
        repeat (4) @(posedge ref_clock);
        repeat (4) @(posedge clk_in);
        #1;
        chk(active === on, "realign in effect");
        @(posedge clk_in);
        realign_n <= 1'b1;
        if (on) wait_for(1, 1'b0);
    endtask : realign
    task automatic check_words(input logic mid);
        @(posedge clk_in);
        #1;
        wait_for(0, 1'b1);
        for (int i = 0; i < LANES; i++)
        begin
            chk(word[i][9:8] === CTRL_W'(i) && (mid || word[i][7:0] ===
                (word[0][7:0] ^ DATA_W'(8'h11 * i))), "lane word");
        end
    endtask : check_words
    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        start(CKSEL_LOW, 1'b0);
        check_words(1'b0);
        realign(1'b0);
        check_words(1'b0);
        chk(err === 4'h0, "bypass error");
        start(CKSEL_MID, 1'b0);
        realign(1'b1);
        check_words(1'b1);
        chk(err === 4'h0, "error after realign");
        start(CKSEL_HIGH, 1'b0);
        realign(1'b1);
        check_words(1'b0);
        start(CKSEL_LOW, 1'b1);
        realign(1'b1);
        wait_for(2, 1'b1);
        wait_for(0, 1'b1);
        @(posedge clk_in);
        wsync <= 4'hF;
        @(posedge clk_in);
        wsync <= 4'h0;
        #1;
        chk(err === 4'h0, "word sync clear");
        wrap_up();
    end
endmodule : tx_input_clock_phase_align_tb_top
